//--- core/tcef_defs.vh
// Register offsets, field positions and timing constants for the tape error-flag block
`ifndef TCEF_DEFS_VH
`define TCEF_DEFS_VH

// ==========================================================
// Register byte offsets
`define TCEF_OFS_CS1 4'h0
`define TCEF_OFS_CS2 4'h4
`define TCEF_OFS_DER 4'h8
`define TCEF_OFS_CTL 4'hc

// ==========================================================
// Drive error register fields
`define TCEF_DER_UNSAFE 14
`define TCEF_DER_DCHK 15

// ==========================================================
// Controller status 2 fields
`define TCEF_CS2_DPAR 8
`define TCEF_CS2_MXF 9
`define TCEF_CS2_OVL 10
`define TCEF_CS2_NOMEM 11
`define TCEF_CS2_NODRV 12
`define TCEF_CS2_XPAR 13
`define TCEF_CS2_CMP 14
`define TCEF_CS2_LATE 15

// ==========================================================
// Controller status 1 fields
`define TCEF_CS1_CPAR 13
`define TCEF_CS1_TRE 14
`define TCEF_CS1_DERR 15

// ==========================================================
// Control register fields
`define TCEF_CTL_CLEAR 0

// ==========================================================
// Timing
`define TCEF_CLK_MHZ 100
`define TCEF_MXF_US 650
`define TCEF_NEM_US 10
`define TCEF_NED_NS 1500
`define TCEF_MXF_CYC (`TCEF_MXF_US * `TCEF_CLK_MHZ)
`define TCEF_NEM_CYC (`TCEF_NEM_US * `TCEF_CLK_MHZ)
`define TCEF_NED_CYC ((`TCEF_NED_NS * `TCEF_CLK_MHZ) / 1000)

// ==========================================================
// Reset values
`define TCEF_RST_16 16'h0000

`endif

//--- core/tcef_error_flags.v
// Error detection and sticky error flags of the tape controller and drive formatter
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`include "tcef_defs.vh"

// What this block does
// [R1] Drive sets unsafe flag when a command targets an unready transport.
// [R2] Drive sets unsafe flag on the power-fail warning input.
// [R3] Drive sets data-check flag on a single dropped track in phase-encoded read.
// [R4] Drive sets data-check flag when NRZI read cyclic check character mismatches computed one.
// [R5] Controller sets data bus parity flag on parity error in read or write-check.
// [R6] Controller sets missed transfer flag when drive does not respond within 650 us.
// [R7] Controller sets overlapped start flag when a transfer starts while busy.
// [R8] Controller sets absent memory flag when memory misses the sync strobe for 10 us.
// [R9] Controller sets absent drive flag when register ack misses 1.5 us after request.
// [R10] Controller sets transfer parity flag on data parity in write or write-check, or on memory address/control parity.
// [R11] Controller sets compare mismatch flag on a write-check word mismatch.
// [R12] Controller sets late data flag when it cannot serve a drive transfer demand.
// [R13] Controller sets control bus parity flag on parity error reading a drive register.
// [R14] Transfer fault summary is the OR of controller status 2 faults and drive error in transfer.
// [R15] Every flag stays set until software or a controller clear removes it.
module tcef_error_flags #(
  parameter MXF_CYCLES = `TCEF_MXF_CYC,
  parameter NEM_CYCLES = `TCEF_NEM_CYC,
  parameter NED_CYCLES = `TCEF_NED_CYC
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Drive side events
  input wire cmd_to_unready_transport,
  input wire power_fail_warning,
  input wire pe_read_active,
  input wire track_dropout,
  input wire nrzi_active,
  input wire check_char_valid,
  input wire [7:0] cyclic_check_character,
  input wire [7:0] computed_check_character,
  // Controller side events
  input wire read_or_wcheck_active,
  input wire write_or_wcheck_active,
  input wire wcheck_active,
  input wire write_active,
  input wire data_bus_parity_err,
  input wire xfer_cmd_issued,
  input wire drive_responded,
  input wire xfer_start_req,
  input wire ctrl_busy,
  input wire dma_active,
  input wire master_sync_strobe,
  input wire mem_slave_sync,
  input wire register_request,
  input wire register_ack,
  input wire ctrl_bus_parity_err,
  input wire drive_reg_read,
  input wire mem_addr_ctl_parity_err,
  input wire tape_word_valid,
  input wire [15:0] tape_word,
  input wire [15:0] mem_word,
  input wire drive_xfer_demand,
  input wire word_available,
  input wire drive_error_in_xfer,
  // Flag outputs
  output wire transfer_fault_summary,
  output wire [15:0] drive_error_register
);

  // ========================================================
  // Bus slave: one wait cycle, answer on the second edge
  reg ack_ff;
  wire req = avs_read | avs_write;
  wire nxt_ack = req & ~ack_ff;
  assign avs_waitrequest = req & ~ack_ff;
  wire wr_take = avs_write & ack_ff;
  wire rd_take = avs_read & ~ack_ff;

  always @(posedge clock) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // Write-one-to-clear mask for a register, honouring the low byte lanes;
  // bus terms are arguments so the mask follows them whenever they change
  function [15:0] w1c;
    input [3:0] ofs;
    input take;
    input [3:0] adr;
    input [15:0] wdat;
    input [1:0] ben;
    begin
      if (take && adr == ofs) begin
        w1c = wdat & {{8{ben[1]}}, {8{ben[0]}}};
      end else begin
        w1c = 16'h0000;
      end
    end
  endfunction

  // Controller clear pulse from the control register
  wire ctl_clear = wr_take && avs_address == `TCEF_OFS_CTL && avs_byteenable[0] &&
    avs_writedata[`TCEF_CTL_CLEAR];
  wire [15:0] clr_der = w1c(`TCEF_OFS_DER, wr_take, avs_address, avs_writedata[15:0],
    avs_byteenable[1:0]);
  wire [15:0] clr_cs2 = w1c(`TCEF_OFS_CS2, wr_take, avs_address, avs_writedata[15:0],
    avs_byteenable[1:0]);
  wire [15:0] clr_cs1 = w1c(`TCEF_OFS_CS1, wr_take, avs_address, avs_writedata[15:0],
    avs_byteenable[1:0]);

  // Software may only clear flag bits; the summary bit is derived, not stored
  localparam [15:0] DER_W1C = (16'h0001 << `TCEF_DER_UNSAFE) | (16'h0001 << `TCEF_DER_DCHK);
  localparam [15:0] CS2_W1C = 16'hffff << `TCEF_CS2_DPAR;
  localparam [15:0] CS1_W1C = (16'h0001 << `TCEF_CS1_CPAR) | (16'h0001 << `TCEF_CS1_DERR);

  // ========================================================
  // Timeout counters
  reg [31:0] mxf_cnt_ff;
  reg mxf_wait_ff;
  reg [31:0] nem_cnt_ff;
  reg [31:0] ned_cnt_ff;
  reg ned_done_ff;

  wire mxf_to = mxf_wait_ff && !drive_responded && mxf_cnt_ff >= MXF_CYCLES - 1; // R6
  wire nem_to = dma_active && master_sync_strobe && !mem_slave_sync &&
    nem_cnt_ff >= NEM_CYCLES - 1; // R8
  wire ned_to = register_request && !register_ack && !ned_done_ff &&
    ned_cnt_ff >= NED_CYCLES - 1; // R9

  // Timers count whole clock cycles; the defaults assume a 100 MHz clock
  always @(posedge clock) begin
    if (sys_rst) begin
      mxf_cnt_ff <= 32'h00000000;
      mxf_wait_ff <= 1'b0;
    end else begin
      // A new command restarts the wait; a timeout reports once
      if (xfer_cmd_issued) begin
        mxf_wait_ff <= 1'b1;
        mxf_cnt_ff <= 32'h00000000;
      end else if (drive_responded || mxf_to || ctl_clear) begin
        mxf_wait_ff <= 1'b0;
      end else if (mxf_wait_ff) begin
        mxf_cnt_ff <= mxf_cnt_ff + 32'h00000001;
      end
    end
  end

  // A strobe that hangs reports again every period, which is harmless
  // because the flag is sticky
  always @(posedge clock) begin
    if (sys_rst) begin
      nem_cnt_ff <= 32'h00000000;
    end else if (dma_active && master_sync_strobe && !mem_slave_sync && !nem_to) begin
      nem_cnt_ff <= nem_cnt_ff + 32'h00000001;
    end else begin
      nem_cnt_ff <= 32'h00000000;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ned_cnt_ff <= 32'h00000000;
      ned_done_ff <= 1'b0;
    end else begin
      // Request must drop before the next one is timed
      if (register_request && !register_ack && !ned_done_ff) begin
        ned_cnt_ff <= ned_cnt_ff + 32'h00000001;
        if (ned_to) begin
          ned_done_ff <= 1'b1;
        end
      end else if (!register_request) begin
        ned_cnt_ff <= 32'h00000000;
        ned_done_ff <= 1'b0;
      end
    end
  end

  // ========================================================
  // Detected events
  wire ev_unsafe = cmd_to_unready_transport | power_fail_warning; // R1 R2
  wire ev_dchk = (pe_read_active & track_dropout) | // R3
    (nrzi_active & check_char_valid & (cyclic_check_character != computed_check_character)); // R4
  wire ev_dpar = data_bus_parity_err & read_or_wcheck_active; // R5
  wire ev_ovl = xfer_start_req & ctrl_busy; // R7
  wire ev_xpar = (data_bus_parity_err & write_or_wcheck_active) | mem_addr_ctl_parity_err; // R10
  wire ev_cmp = wcheck_active & tape_word_valid & (tape_word != mem_word); // R11
  wire ev_late = drive_xfer_demand & ~word_available &
    (write_active | read_or_wcheck_active); // R12
  wire ev_cpar = ctrl_bus_parity_err & drive_reg_read; // R13

  // ========================================================
  // Sticky flags: a set in the clear cycle wins
  reg [15:0] der_ff;
  reg [15:0] cs2_ff;
  reg [15:0] cs1_ff;
  reg [15:0] nxt_der;
  reg [15:0] nxt_cs2;
  reg [15:0] nxt_cs1;

  always @* begin
    nxt_der = ctl_clear ? 16'h0000 : (der_ff & ~(clr_der & DER_W1C)); // R15
    if (ev_unsafe) begin
      nxt_der[`TCEF_DER_UNSAFE] = 1'b1; // R1 R2
    end
    if (ev_dchk) begin
      nxt_der[`TCEF_DER_DCHK] = 1'b1; // R3 R4
    end
  end

  always @* begin
    nxt_cs2 = ctl_clear ? 16'h0000 : (cs2_ff & ~(clr_cs2 & CS2_W1C)); // R15
    if (ev_dpar) begin
      nxt_cs2[`TCEF_CS2_DPAR] = 1'b1; // R5
    end
    if (mxf_to) begin
      nxt_cs2[`TCEF_CS2_MXF] = 1'b1; // R6
    end
    if (ev_ovl) begin
      nxt_cs2[`TCEF_CS2_OVL] = 1'b1; // R7
    end
    if (nem_to) begin
      nxt_cs2[`TCEF_CS2_NOMEM] = 1'b1; // R8
    end
    if (ned_to) begin
      nxt_cs2[`TCEF_CS2_NODRV] = 1'b1; // R9
    end
    if (ev_xpar) begin
      nxt_cs2[`TCEF_CS2_XPAR] = 1'b1; // R10
    end
    if (ev_cmp) begin
      nxt_cs2[`TCEF_CS2_CMP] = 1'b1; // R11
    end
    if (ev_late) begin
      nxt_cs2[`TCEF_CS2_LATE] = 1'b1; // R12
    end
  end

  always @* begin
    nxt_cs1 = ctl_clear ? 16'h0000 : (cs1_ff & ~(clr_cs1 & CS1_W1C)); // R15
    if (ev_cpar) begin
      nxt_cs1[`TCEF_CS1_CPAR] = 1'b1; // R13
    end
    if (drive_error_in_xfer) begin
      nxt_cs1[`TCEF_CS1_DERR] = 1'b1; // R14
    end
    nxt_cs1[`TCEF_CS1_TRE] = 1'b0;
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      der_ff <= `TCEF_RST_16;
      cs2_ff <= `TCEF_RST_16;
      cs1_ff <= `TCEF_RST_16;
    end else begin
      der_ff <= nxt_der;
      cs2_ff <= nxt_cs2;
      cs1_ff <= nxt_cs1;
    end
  end

  // Summary is derived, so clearing the causes clears it too; it is built from
  // the next flag values so the pin moves on the same edge as the flags
  reg sum_ff;
  wire nxt_sum = (|nxt_cs2[`TCEF_CS2_LATE:`TCEF_CS2_DPAR]) | nxt_cs1[`TCEF_CS1_DERR]; // R14
  always @(posedge clock) begin
    if (sys_rst) begin
      sum_ff <= 1'b0;
    end else begin
      sum_ff <= nxt_sum;
    end
  end
  assign transfer_fault_summary = sum_ff; // R14
  assign drive_error_register = der_ff;

  // ========================================================
  // Read data, registered at the wait-cycle edge, one edge before the accepting edge
  always @(posedge clock) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_take) begin
      case (avs_address)
        `TCEF_OFS_CS1: avs_readdata <= {16'h0000, cs1_ff[15],
          transfer_fault_summary, cs1_ff[13:0]};
        `TCEF_OFS_CS2: avs_readdata <= {16'h0000, cs2_ff};
        `TCEF_OFS_DER: avs_readdata <= {16'h0000, der_ff};
        // Control register is write-only
        `TCEF_OFS_CTL: avs_readdata <= 32'h00000000;
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule

//--- sim/tcef_drive_model.sv
// Behavioural drive formatter answering transfer commands and register requests
`timescale 1ns/10ps
// ==========================================================
// Drive model
module tcef_drive_model (
  // Clock
  input wire clock,
  // Controller requests and presence select
  input wire xfer_cmd_issued,
  input wire register_request,
  input wire absent,
  // Answers
  output wire drive_responded,
  output wire register_ack
);
  logic [2:0] dly_ff = 3'b000;
  always @(posedge clock) begin
    dly_ff <= {dly_ff[1:0], xfer_cmd_issued | register_request};
  end
  // An absent drive never answers, so the missed transfer and absent drive timers must expire
  assign drive_responded = !absent && dly_ff[2];
  assign register_ack = !absent && register_request && dly_ff[2];
endmodule

//--- sim/tcef_error_flags_asserts.sv
// Port-level assertions for the tape error-flag block
`timescale 1ns/10ps
// ==========================================================
// Checker
module tcef_chk (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Register bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Events
  input wire cmd_to_unready_transport,
  input wire power_fail_warning,
  input wire read_or_wcheck_active,
  input wire data_bus_parity_err,
  input wire xfer_start_req,
  input wire ctrl_busy,
  // Flags
  input wire transfer_fault_summary,
  input wire [15:0] drive_error_register
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_held;
    avs_read || avs_write;
  endsequence
  a_wait_one: assert property (s_req ##1 s_held |-> !avs_waitrequest)
    else $error("bus request waited more than one cycle");
  a_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus request answered without its wait cycle");
  a_unsafe_pwr: assert property (power_fail_warning |=> drive_error_register[14])
    else $error("power warning did not set unsafe flag");
  a_unsafe_cmd: assert property (cmd_to_unready_transport |=> drive_error_register[14])
    else $error("command to unready transport did not set unsafe flag");
  a_dpar_sum: assert property (read_or_wcheck_active && data_bus_parity_err
    |=> transfer_fault_summary) else $error("data parity did not raise summary");
  a_ovl_sum: assert property (xfer_start_req && ctrl_busy |=> transfer_fault_summary)
    else $error("start while busy did not raise summary");
  a_unsafe_hold: assert property (drive_error_register[14] && !avs_write
    |=> drive_error_register[14]) else $error("unsafe flag dropped without software");
  a_sum_hold: assert property (transfer_fault_summary && !avs_write
    |=> transfer_fault_summary) else $error("summary dropped without software");
endmodule

//--- sim/tcef_error_flags_tb.sv
// Self-checking bench for the tape error-flag block
`timescale 1ns/10ps
`include "tcef_defs.vh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
module tcef_error_flags_tb;
  localparam MISSED_TRANSFER_FLAG = 20;
  localparam ABSENT_MEMORY_FLAG = 10;
  localparam ABSENT_DRIVE_FLAG = 5;
  logic clock = 0, sys_rst = 1, avs_read = 0, avs_write = 0, absent = 0;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, q;
  logic [14:0] ev = 0;
  int miscompares = 0, cmp_count = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, transfer_fault_summary, drive_responded, register_ack;
  wire [15:0] drive_error_register;
  // ==========================================================
  // One event bit per fault source except memory address/control parity; bit 14 is a case where no fault may set
  logic drive_reg_read = 1, write_active = 0, mem_addr_ctl_parity_err = 0;
  logic [3:0] avs_byteenable = 4'hf;
  wire read_or_wcheck_active = ev[0] | ev[6] | (ev[7] & ~write_active);
  wire xfer_cmd_issued = ev[1];
  wire xfer_start_req = ev[2], ctrl_busy = ev[2], dma_active = ev[3];
  wire master_sync_strobe = ev[3], register_request = ev[4];
  wire write_or_wcheck_active = ev[5] | ev[6], data_bus_parity_err = ev[0] | ev[5];
  wire wcheck_active = ev[6], tape_word_valid = ev[6], drive_xfer_demand = ev[7];
  wire word_available = ~ev[7], ctrl_bus_parity_err = ev[8], drive_error_in_xfer = ev[9];
  wire power_fail_warning = ev[10], cmd_to_unready_transport = ev[11];
  wire pe_read_active = ev[12], track_dropout = ev[12], nrzi_active = ev[13] | ev[14];
  wire check_char_valid = nrzi_active, mem_slave_sync = ev[14] & ev[3];
  wire [7:0] cyclic_check_character = ev[14:7];
  wire [7:0] computed_check_character = ev[14:7] ^ {7'h00, ev[13]};
  wire [15:0] tape_word = {1'b0, ev};
  wire [15:0] mem_word = {1'b0, ev} ^ {15'h0000, ev[6]};
  tcef_error_flags #(.MXF_CYCLES(MISSED_TRANSFER_FLAG), .NEM_CYCLES(ABSENT_MEMORY_FLAG), .NED_CYCLES(ABSENT_DRIVE_FLAG)) dut_u (.*);
  tcef_drive_model drv_u (.*);
  initial forever #5 clock = ~clock;
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  function automatic logic [19:0] expect_of(int i);
    case (i)
      8: return {`TCEF_OFS_CS1, 16'h2000};
      9: return {`TCEF_OFS_CS1, 16'hc000};
      10, 11: return {`TCEF_OFS_DER, 16'h4000};
      12, 13: return {`TCEF_OFS_DER, 16'h8000};
      14: return {`TCEF_OFS_CS2, 16'h0000};
      default: return {`TCEF_OFS_CS2, 16'h0100 << i};
    endcase
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    bus(1, 4'h2, 16'hffff);
    for (int a = 0; a < 12; a += 2) begin
      bus(0, a[3:0], 16'h0000);
      `CHK("reset or unmapped", 32'h0, q)
    end
  endtask
  // Last case keeps every partner prompt and the check characters equal: nothing may set
  task automatic t_events;
    logic [19:0] e;
    for (int i = 0; i < 15; i++) begin
      e = expect_of(i);
      absent <= (i == 1 || i == 4);
      ev <= (i == 14) ? 15'h401a : 15'h0001 << i;
      repeat ((i == 3 || i == 4 || i == 14) ? ABSENT_MEMORY_FLAG + 5 : 1) @(posedge clock);
      ev <= 0;
      repeat (MISSED_TRANSFER_FLAG + 5) @(posedge clock);
      bus(0, e[19:16], 16'h0000);
      `CHK("flag", {16'h0, e[15:0]}, q)
      if (e[19:16] == `TCEF_OFS_DER)
        `CHK("error port", e[15:0], drive_error_register)
      if (i < 10)
        `CHK("summary", (i < 8 || i == 9), transfer_fault_summary)
      bus(1, i < 8 ? e[19:16] : `TCEF_OFS_CTL, i < 8 ? e[15:0] : 16'h0001);
      bus(0, e[19:16], 16'h0000);
      `CHK("cleared", 32'h0, q)
    end
  endtask
  // Inputs the event table leaves idle, lane-masked and overlapping clears, mid-run reset
  task automatic t_paths;
    mem_addr_ctl_parity_err <= 1;
    @(posedge clock);
    mem_addr_ctl_parity_err <= 0;
    avs_byteenable <= 4'h1;
    bus(1, `TCEF_OFS_CS2, 16'hffff);
    avs_byteenable <= 4'hf;
    bus(0, `TCEF_OFS_CS2, 16'h0000);
    `CHK("lane-masked clear", 32'h2000, q)
    `CHK("summary", 1'b1, transfer_fault_summary)
    bus(1, `TCEF_OFS_CS2, 16'h2000);
    write_active <= 1;
    ev <= 15'h0080;
    @(posedge clock);
    write_active <= 0;
    ev <= 0;
    bus(0, `TCEF_OFS_CS2, 16'h0000);
    `CHK("late data on write", 32'h8000, q)
    bus(1, `TCEF_OFS_CS2, 16'h8000);
    drive_reg_read <= 0;
    ev <= 15'h0100;
    @(posedge clock);
    drive_reg_read <= 1;
    ev <= 0;
    bus(0, `TCEF_OFS_CS1, 16'h0000);
    `CHK("parity outside register read", 32'h0, q)
    ev <= 15'h0400;
    bus(1, `TCEF_OFS_DER, 16'hc000);
    @(posedge clock);
    `CHK("set beats clear", 16'h4000, drive_error_register)
    ev <= 15'h0420;
    @(posedge clock);
    ev <= 0;
    sys_rst <= 1;
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    bus(0, `TCEF_OFS_CS2, 16'h0000);
    `CHK("reset clears status 2", 32'h0, q)
    `CHK("reset clears drive errors", 16'h0000, drive_error_register)
    `CHK("summary after reset", 1'b0, transfer_fault_summary)
  endtask
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 0;
    t_reset();
    t_events();
    t_paths();
    report_and_stop();
  end
endmodule
bind tcef_error_flags tcef_chk chk_u (.*);
